// [logic/gtc_cfg.svh]
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH

// register map: byte address = unit * 16 + word * 4
`define GTC_UNIT_A 3'h0
`define GTC_UNIT_LAST 4'h4
`define GTC_W_CTL 2'h0
`define GTC_W_CNT 2'h1
`define GTC_W_PER 2'h2
`define GTC_W_NONE 2'h3

// control field positions
`define GTC_ON_BIT 15
`define GTC_STOP_IN_IDLE_BIT 13
`define GTC_WDIS_BIT 12
`define GTC_WIP_BIT 11
`define GTC_GATE_BIT 7
`define GTC_PS_LSB 4
`define GTC_A_PS_MSB 5
`define GTC_B_PS_MSB 6
`define GTC_T32_BIT 3
`define GTC_SYNC_BIT 2
`define GTC_TCS_BIT 1

// reset values
`define GTC_CNT_RST 16'h0000
`define GTC_PER_RST 16'hffff

// timing
`define GTC_CLK_NS 25
`define GTC_ASYNC_WR_NS 75
`define GTC_ASYNC_WR_CYC \
  ((`GTC_ASYNC_WR_NS + `GTC_CLK_NS - 1) / `GTC_CLK_NS)
`endif

// [logic/gtc_pkg.sv]
`default_nettype none
package gtc_pkg;
  // async timer control fields
  typedef struct packed {
    logic on;
    logic stop_in_idle;
    logic wdis;
    logic gate;
    logic [1:0] ps;
    logic sync;
    logic clock_source_select;
  } gtc_actl_t;
  // pairable timer control fields
  typedef struct packed {
    logic on;
    logic stop_in_idle;
    logic gate;
    logic [2:0] ps;
    logic t32;
    logic clock_source_select;
  } gtc_bctl_t;
  // decoded bus address
  typedef struct packed {
    logic hit;
    logic [2:0] unit;
    logic [1:0] word;
  } gtc_dec_t;
  // async count write transfer
  typedef enum logic {
    GTC_WR_IDLE = 1'b0,
    GTC_WR_BUSY = 1'b1
  } gtc_wr_state_t;
endpackage
`default_nettype wire

// [logic/gtc_top.sv]
`timescale 1ns/1ps
`include "gtc_cfg.svh"
`default_nettype none
module gtc_top
  import gtc_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // device idle and timer pins, bit 0 is the async timer
  input wire logic IDLE_IN,
  input wire logic [4:0] EXT_CLK_IN,
  input wire logic [4:0] GATE_IN,
  // period match pulses, bit 0 is the async timer
  output logic [4:0] MATCH_OUT
);

  // decode one address into unit and word
  function automatic gtc_dec_t gtc_decode(input logic [11:0] a);
    gtc_dec_t d;
    d.unit = a[6:4];
    d.word = a[3:2];
    d.hit = (a[11:8] == 4'h0) && (a[7:4] <= `GTC_UNIT_LAST) &&
            (a[3:2] != `GTC_W_NONE);
    return d;
  endfunction

  // last prescaler value of the async timer
  function automatic logic [7:0] gtc_div_a(input logic [1:0] ps);
    case (ps)
      2'h0: gtc_div_a = 8'h00;
      2'h1: gtc_div_a = 8'h07;
      2'h2: gtc_div_a = 8'h3f;
      default: gtc_div_a = 8'hff;
    endcase
  endfunction

  // last prescaler value of a pairable timer
  function automatic logic [7:0] gtc_div_b(input logic [2:0] ps);
    case (ps)
      3'h0: gtc_div_b = 8'h00;
      3'h1: gtc_div_b = 8'h01;
      3'h2: gtc_div_b = 8'h03;
      3'h3: gtc_div_b = 8'h07;
      3'h4: gtc_div_b = 8'h0f;
      3'h5: gtc_div_b = 8'h1f;
      3'h6: gtc_div_b = 8'h3f;
      default: gtc_div_b = 8'hff;
    endcase
  endfunction

  // unpack a written async control word, upper half dropped
  function automatic gtc_actl_t gtc_a_ctl(input logic [31:0] w);
    gtc_actl_t c;
    c.on = w[`GTC_ON_BIT];
    c.stop_in_idle = w[`GTC_STOP_IN_IDLE_BIT];
    c.wdis = w[`GTC_WDIS_BIT];
    c.gate = w[`GTC_GATE_BIT];
    c.ps = w[`GTC_A_PS_MSB:`GTC_PS_LSB];
    c.sync = w[`GTC_SYNC_BIT];
    c.clock_source_select = w[`GTC_TCS_BIT];
    return c;
  endfunction

  // unpack a written pairable control word
  function automatic gtc_bctl_t gtc_b_ctl(input logic [31:0] w,
                                          input logic even);
    gtc_bctl_t c;
    c.on = w[`GTC_ON_BIT];
    c.stop_in_idle = w[`GTC_STOP_IN_IDLE_BIT];
    c.gate = w[`GTC_GATE_BIT];
    c.ps = w[`GTC_B_PS_MSB:`GTC_PS_LSB];
    c.t32 = even & w[`GTC_T32_BIT];
    c.clock_source_select = w[`GTC_TCS_BIT];
    return c;
  endfunction

  // pack async control for reading
  function automatic logic [31:0] gtc_a_word(input gtc_actl_t c,
                                             input logic wip);
    logic [31:0] w;
    w = 32'h0;
    w[`GTC_ON_BIT] = c.on;
    w[`GTC_STOP_IN_IDLE_BIT] = c.stop_in_idle;
    w[`GTC_WDIS_BIT] = c.wdis;
    w[`GTC_WIP_BIT] = wip;
    w[`GTC_GATE_BIT] = c.gate;
    w[`GTC_A_PS_MSB:`GTC_PS_LSB] = c.ps;
    w[`GTC_SYNC_BIT] = c.sync;
    w[`GTC_TCS_BIT] = c.clock_source_select;
    return w;
  endfunction

  // pack pairable control for reading
  function automatic logic [31:0] gtc_b_word(input gtc_bctl_t c);
    logic [31:0] w;
    w = 32'h0;
    w[`GTC_ON_BIT] = c.on;
    w[`GTC_STOP_IN_IDLE_BIT] = c.stop_in_idle;
    w[`GTC_GATE_BIT] = c.gate & ~c.clock_source_select;
    w[`GTC_B_PS_MSB:`GTC_PS_LSB] = c.ps;
    w[`GTC_T32_BIT] = c.t32;
    w[`GTC_TCS_BIT] = c.clock_source_select;
    return w;
  endfunction

  // pin synchronisers; stage 3 feeds edge detection only
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  logic [10:0] pin_s3_q;
  logic a_s4_q;
  logic [4:0] clk_edge;
  logic [4:0] gate_s;
  logic idle_s;
  logic a_edge_sync;

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pin_s1_q <= 11'h000;
      pin_s2_q <= 11'h000;
      pin_s3_q <= 11'h000;
      a_s4_q <= 1'b0;
    end else begin
      pin_s1_q <= {IDLE_IN, GATE_IN, EXT_CLK_IN};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      a_s4_q <= pin_s3_q[0];
    end
  end

  assign clk_edge = pin_s2_q[4:0] & ~pin_s3_q[4:0];
  assign gate_s = pin_s2_q[9:5];
  assign idle_s = pin_s2_q[10];
  assign a_edge_sync = pin_s3_q[0] & ~a_s4_q;

  // bus slave state
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic apb_wr;
  gtc_dec_t dec;
  logic [31:0] rd_word;

  assign dec = gtc_decode(PADDR_IN);
  // a write lands only at the edge that completes the access phase
  assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & pready_q;

  // async timer state
  gtc_actl_t a_ctl_q, a_ctl_d;
  logic [15:0] a_cnt_q, a_cnt_d;
  logic [15:0] a_per_q, a_per_d;
  logic [15:0] a_wdat_q, a_wdat_d;
  logic [7:0] a_psc_q, a_psc_d;
  logic [1:0] a_wcnt_q, a_wcnt_d;
  gtc_wr_state_t a_wst_q, a_wst_d;
  logic a_hit_q, a_hit_d;
  logic a_src;
  logic a_stop;
  logic a_async;

  // pairable timer state
  gtc_bctl_t b_ctl_q [4];
  gtc_bctl_t b_ctl_d [4];
  logic [15:0] b_cnt_q [4];
  logic [15:0] b_cnt_d [4];
  logic [15:0] b_per_q [4];
  logic [15:0] b_per_d [4];
  logic [7:0] b_psc_q [4];
  logic [7:0] b_psc_d [4];
  logic [3:0] b_hit_q, b_hit_d;

  // async mode: external clock taken without the extra sync stage
  assign a_async = a_ctl_q.clock_source_select & ~a_ctl_q.sync;

  // register read mux, sampled in the setup cycle
  always_comb begin
    rd_word = 32'h0;
    if (dec.unit == `GTC_UNIT_A) begin
      case (dec.word)
        `GTC_W_CTL: rd_word = gtc_a_word(a_ctl_q,
                      (a_wst_q == GTC_WR_BUSY) & a_async);
        `GTC_W_CNT: rd_word = {16'h0000, a_cnt_q};
        `GTC_W_PER: rd_word = {16'h0000, a_per_q};
        default: rd_word = 32'h0;
      endcase
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (dec.unit == 3'(i + 1)) begin
          case (dec.word)
            `GTC_W_CTL: rd_word = gtc_b_word(b_ctl_q[i]);
            `GTC_W_CNT: rd_word = {16'h0000, b_cnt_q[i]};
            `GTC_W_PER: rd_word = {16'h0000, b_per_q[i]};
            default: rd_word = 32'h0;
          endcase
        end
      end
    end
  end

  // zero wait state: ready rises for the access cycle after setup
  always_comb begin
    pready_d = PSEL_IN & ~PENABLE_IN;
    pslverr_d = PSEL_IN & ~PENABLE_IN & ~dec.hit;
    prdata_d = 32'h0;
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && dec.hit) begin
      prdata_d = rd_word;
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // async timer next state
  always_comb begin
    a_ctl_d = a_ctl_q;
    a_cnt_d = a_cnt_q;
    a_per_d = a_per_q;
    a_psc_d = a_psc_q;
    a_wst_d = a_wst_q;
    a_wcnt_d = a_wcnt_q;
    a_wdat_d = a_wdat_q;
    a_hit_d = 1'b0;
    // gate only matters on the internal clock
    a_src = a_ctl_q.clock_source_select ? (a_ctl_q.sync ? a_edge_sync : clk_edge[0])
                        : (!a_ctl_q.gate || gate_s[0]);
    a_stop = idle_s && a_ctl_q.stop_in_idle;
    if (!a_ctl_q.on) begin
      a_psc_d = 8'h00;
    end else if (!a_stop && a_src) begin
      if (a_psc_q >= gtc_div_a(a_ctl_q.ps)) begin
        a_psc_d = 8'h00;
        if (a_cnt_q == a_per_q) begin
          a_cnt_d = `GTC_CNT_RST;
          a_hit_d = 1'b1;
        end else begin
          a_cnt_d = a_cnt_q + 16'h0001;
        end
      end else begin
        a_psc_d = a_psc_q + 8'h01;
      end
    end
    // pending count write lands once its transfer time has run out
    case (a_wst_q)
      GTC_WR_IDLE: begin
        a_wcnt_d = 2'h0;
      end
      GTC_WR_BUSY: begin
        if (a_wcnt_q == 2'h0) begin
          a_cnt_d = a_wdat_q;
          a_wst_d = GTC_WR_IDLE;
        end else begin
          a_wcnt_d = a_wcnt_q - 2'h1;
        end
      end
      default: a_wst_d = GTC_WR_IDLE;
    endcase
    // software writes win over counting in the same cycle, except async-mode count writes, which go pending instead, or are dropped while one is pending with wdis set
    if (apb_wr && dec.hit && dec.unit == `GTC_UNIT_A) begin
      case (dec.word)
        `GTC_W_CTL: a_ctl_d = gtc_a_ctl(PWDATA_IN);
        `GTC_W_PER: a_per_d = PWDATA_IN[15:0];
        `GTC_W_CNT: begin
          if (!a_async) begin
            a_cnt_d = PWDATA_IN[15:0];
          end else if (!(a_wst_q == GTC_WR_BUSY && a_ctl_q.wdis)) begin
            a_wdat_d = PWDATA_IN[15:0];
            a_wst_d = GTC_WR_BUSY;
            a_wcnt_d = 2'(`GTC_ASYNC_WR_CYC - 1);
          end
        end
        default: a_wst_d = a_wst_q;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      a_ctl_q <= '0;
      a_cnt_q <= `GTC_CNT_RST;
      a_per_q <= `GTC_PER_RST;
      a_wdat_q <= `GTC_CNT_RST;
      a_psc_q <= 8'h00;
      a_wcnt_q <= 2'h0;
      a_wst_q <= GTC_WR_IDLE;
      a_hit_q <= 1'b0;
    end else begin
      a_ctl_q <= a_ctl_d;
      a_cnt_q <= a_cnt_d;
      a_per_q <= a_per_d;
      a_wdat_q <= a_wdat_d;
      a_psc_q <= a_psc_d;
      a_wcnt_q <= a_wcnt_d;
      a_wst_q <= a_wst_d;
      a_hit_q <= a_hit_d;
    end
  end

  // pairable timers next state
  always_comb begin
    gtc_bctl_t c;
    logic pair;
    logic stop;
    logic src;
    logic [31:0] wide;
    c = '0;
    pair = 1'b0;
    stop = 1'b0;
    src = 1'b0;
    wide = 32'h0;
    b_ctl_d = b_ctl_q;
    b_cnt_d = b_cnt_q;
    b_per_d = b_per_q;
    b_psc_d = b_psc_q;
    b_hit_d = 4'h0;
    for (int i = 0; i < 4; i++) begin
      // an odd timer in a pair is driven by its even partner
      if ((i % 2 == 1) && b_ctl_q[i & 2].t32) begin
        b_psc_d[i] = 8'h00;
      end else begin
        c = b_ctl_q[i];
        pair = (i % 2 == 0) && c.t32;
        // pair halts in idle unless both halves allow it
        stop = idle_s && (c.stop_in_idle || (pair && b_ctl_q[i | 1].stop_in_idle));
        src = c.clock_source_select ? clk_edge[i + 1]
                    : (!c.gate || gate_s[i + 1]);
        if (!c.on) begin
          b_psc_d[i] = 8'h00;
        end else if (!stop && src) begin
          if (b_psc_q[i] >= gtc_div_b(c.ps)) begin
            b_psc_d[i] = 8'h00;
            wide = pair ? {b_cnt_q[i | 1], b_cnt_q[i]}
                        : {16'h0000, b_cnt_q[i]};
            if (wide == (pair ? {b_per_q[i | 1], b_per_q[i]}
                              : {16'h0000, b_per_q[i]})) begin
              wide = 32'h0;
              b_hit_d[i] = 1'b1;
            end else begin
              wide = wide + 32'h1;
            end
            b_cnt_d[i] = wide[15:0];
            if (pair) begin
              b_cnt_d[i | 1] = wide[31:16];
            end
          end else begin
            b_psc_d[i] = b_psc_q[i] + 8'h01;
          end
        end
      end
    end
    // software writes win over counting in the same cycle
    for (int i = 0; i < 4; i++) begin
      if (apb_wr && dec.hit && dec.unit == 3'(i + 1)) begin
        case (dec.word)
          `GTC_W_CTL: b_ctl_d[i] = gtc_b_ctl(PWDATA_IN, i % 2 == 0);
          `GTC_W_CNT: b_cnt_d[i] = PWDATA_IN[15:0];
          `GTC_W_PER: b_per_d[i] = PWDATA_IN[15:0];
          default: b_per_d[i] = b_per_q[i];
        endcase
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < 4; i++) begin
        b_ctl_q[i] <= '0;
        b_cnt_q[i] <= `GTC_CNT_RST;
        b_per_q[i] <= `GTC_PER_RST;
        b_psc_q[i] <= 8'h00;
      end
      b_hit_q <= 4'h0;
    end else begin
      b_ctl_q <= b_ctl_d;
      b_cnt_q <= b_cnt_d;
      b_per_q <= b_per_d;
      b_psc_q <= b_psc_d;
      b_hit_q <= b_hit_d;
    end
  end

  // outputs straight from flip-flops
  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign MATCH_OUT = {b_hit_q, a_hit_q};

endmodule
`default_nettype wire

// [tb/gtc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module gtc_chk (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // apb slave side
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // timer pulses
  input wire logic [4:0] MATCH_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // setup phase seen on the bus
  wire logic setup;
  assign setup = PSEL_IN && !PENABLE_IN;

  a_ready_next: assert property (setup |=> PREADY_OUT)
    else $error("ready not one cycle after setup");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  a_ready_cause: assert property (PREADY_OUT |-> $past(setup))
    else $error("ready without setup");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error outside access");
  a_rdata_quiet: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data not cleared");
  a_upper_zero: assert property (
    PREADY_OUT |-> PRDATA_OUT[31:16] == 16'h0)
    else $error("upper read bits set");
  a_hole_err: assert property (setup && PADDR_IN[3:2] == 2'h3
    |=> PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("unmapped word not refused");
  a_page_err: assert property (
    setup && PADDR_IN[11:8] != 4'h0 |=> PSLVERR_OUT)
    else $error("high page not refused");
  a_pend_async: assert property (
    setup && !PWRITE_IN && PADDR_IN[3:2] == 2'h0
    && PADDR_IN[7:4] != 4'h0 |=> !PRDATA_OUT[11])
    else $error("pending bit on pairable timer");
  a_pair_even: assert property (
    setup && !PWRITE_IN && PADDR_IN[3:2] == 2'h0
    && (PADDR_IN[7:4] == 4'h2 || PADDR_IN[7:4] == 4'h4) |=> !PRDATA_OUT[3])
    else $error("pair bit on odd timer");
  // main scenarios reached
  c_refused: cover property (PSLVERR_OUT);
  c_match: cover property (MATCH_OUT != 5'h0);
  c_pending: cover property (PREADY_OUT && PRDATA_OUT[11]);
endmodule
bind gtc_top gtc_chk u_chk (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .MATCH_OUT(MATCH_OUT));
`default_nettype wire

// [tb/tb_general_timer_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_general_timer_control;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, idle = 0, prdy, perr;
  logic err;
  logic [11:0] padr = 0;
  logic [31:0] pwd = 0, prd, rd, v, a, b, d;
  logic [4:0] ext = 0, gate = 0, match;
  int fails = 0, n_compared = 0;
  int adiv[4] = '{1, 8, 64, 256};
  int bdiv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  gtc_top dut (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .IDLE_IN(idle), .EXT_CLK_IN(ext), .GATE_IN(gate), .MATCH_OUT(match));
  always #12.5 clk = ~clk;
  // free-running external clocks, one rise every two bus cycles
  always @(posedge clk) ext <= ~ext;
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function logic [11:0] adr(input int u, input int w);
    return 12'(u * 16 + w * 4);
  endfunction
  // model of control readback: pair bit on units 1 and 3 only
  function logic [31:0] ctl_exp(input int u, input logic [31:0] x);
    logic [31:0] r;
    if (u == 0) return x & 32'hb0b6;
    r = x & ((u % 2) ? 32'ha0fa : 32'ha0f2);
    if (x[1]) r[7] = 1'b0;
    return r;
  endfunction
  // request stays up until ready is sampled; release left to tick
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1;
    pen <= 0;
    pwr <= w;
    padr <= ad;
    pwd <= wd;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) chk("ready", 0, 1);
    rd = prd;
    err = perr;
  endtask
  task tick(input int k);
    psel <= 0;
    pen <= 0;
    repeat (k) @(posedge clk);
  endtask
  // gap between two wrap pulses with period one
  task meas(input int u, input logic [31:0] c, input int exp);
    int n;
    apb(1, adr(u, 2), 1);
    apb(1, adr(u, 1), 0);
    apb(1, adr(u, 0), c);
    tick(1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (match[u] !== 1'b1 && n < 3000);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (match[u] !== 1'b1 && n < 3000);
    chk("match gap", n, exp);
    apb(1, adr(u, 0), 0);
    // quiet cycle after the enable is cleared
    tick(1);
  endtask
  task summarize;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(20000 * 25);
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(36));
    repeat (4) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    for (int u = 0; u < 5; u++) begin
      apb(0, adr(u, 0), 0);
      chk("ctl reset", rd, 0);
      apb(0, adr(u, 2), 0);
      chk("period reset", rd, 32'hffff);
      for (int k = 0; k < 3; k++) begin
        d = (k == 0) ? 32'hffffffff : (k == 1) ? 32'hfffffffd : $urandom;
        apb(1, adr(u, 0), d);
        apb(0, adr(u, 0), 0);
        chk("ctl read", rd, ctl_exp(u, d));
      end
      apb(1, adr(u, 0), 0);
    end
    apb(0, 12'h00c, 0);
    chk("hole err", err, 1);
    apb(1, 12'h100, 32'hffffffff);
    chk("page err", err, 1);
    $display("registers done");
    for (int c = 0; c < 4; c++) begin
      meas(0, 32'h8000 | (c << 4), 2 * adiv[c]);
    end
    for (int c = 0; c < 8; c++) begin
      meas(2, 32'h8000 | (c << 4), 2 * bdiv[c]);
    end
    meas(4, 32'h8092, 8);
    meas(0, 32'h8082, 4);
    meas(0, 32'h8086, 4);
    // pair: odd half disabled and zeroed, even half rules
    apb(1, adr(2, 1), 0);
    apb(1, adr(2, 2), 0);
    apb(1, adr(2, 0), 0);
    meas(1, 32'h8008, 2);
    $display("counting done");
    for (int k = 0; k < 16; k++) begin
      idle <= k[1];
      gate <= {5{k[3]}};
      apb(1, adr(3, 0), 32'h8000 | (k[0] << 13) | (k[2] << 7));
      tick(4);
      apb(0, adr(3, 1), 0);
      v = rd;
      apb(0, adr(3, 1), 0);
      // gate bit blocks counting only while the gate pin is low
      d = ((k[0] && k[1]) || (k[2] && !k[3])) ? 0 : 2;
      chk("idle gate step", rd - v, d);
    end
    apb(1, adr(3, 0), 0);
    gate <= 0;
    // chained pair runs in idle only while the odd half allows it
    apb(1, adr(1, 2), 32'hffff);
    idle <= 1;
    for (int k = 0; k < 2; k++) begin
      apb(1, adr(2, 0), k << 13);
      apb(1, adr(1, 0), 32'h8008);
      tick(4);
      apb(0, adr(1, 1), 0);
      v = rd;
      apb(0, adr(1, 1), 0);
      chk("pair idle step", rd - v, k ? 0 : 2);
      apb(1, adr(1, 0), 0);
    end
    apb(1, adr(2, 0), 0);
    idle <= 0;
    $display("idle and gate done");
    for (int k = 0; k < 2; k++) begin
      apb(1, adr(0, 0), 32'h0002 | (k << 12));
      a = $urandom & 32'hffff;
      b = $urandom & 32'hffff;
      apb(1, adr(0, 1), a);
      apb(1, adr(0, 1), b);
      apb(0, adr(0, 0), 0);
      if (k == 0) chk("pending bit", rd[11], 1);
      tick(8);
      apb(0, adr(0, 1), 0);
      chk("count load", rd, k ? a : b);
      apb(0, adr(0, 0), 0);
      chk("pending clear", rd[11], 0);
    end
    tick(1);
    $display("async write done");
    summarize();
  end
endmodule
`default_nettype wire
